// ==== rtl/alt_function_io_pkg.sv ====
// Purpose: Constants shared by the alternate-function remap block.
// Assumes: APB4 slave, 32-bit data, word-aligned registers.
// Notes:   Pin codes are {port, pin number}; all ones means no pin.
// Operation
// - Two external-interrupt configuration words sit at 0x40010008 and 0x4001000C and reset to zero.
// - The debug-port select field in bits 26 to 24 resets to zero so the debug pins start as the debug port.
// - A debug select value with its top bit clear keeps the debug port, 100 frees its pins, others are invalid.
// - Bit 23 puts the programmable controller lines on PC18 and PC19, or on PC7 and PC19 when set.
// - Timer 3 bits 22 to 21 put channels 1 and 2 on PA6/PA7, PB4/PB5, PC19/PC18 or PA3/PA4.
// - The timer 3 external trigger stays on PD2 whatever the timer 3 field holds.
// - Timer 2 bits 20 to 18 pick one of seven pin sets, codes 11x ignoring the lowest bit.
// - Timer 1 bits 17 to 15 cross the half-word edge; codes 000 and 001 differ only in break and complementary pins.
// - Bits 31 to 27 of the remap word read as zero and ignore writes.
// - Timer 1 code 011 puts channels on PC0 to PC3, trigger on PC18, break on PC4, complementary on PC5 to PC7.
package alt_function_io_pkg;

	// ------------------------------------------------------------
	// Register map
	// ------------------------------------------------------------
	localparam logic [31:0] ADDR_PIN_REMAP_ONE      = 32'h40010004;
	localparam logic [31:0] ADDR_EXT_IRQ_CONFIG_ONE = 32'h40010008;
	localparam logic [31:0] ADDR_EXT_IRQ_CONFIG_TWO = 32'h4001000C;
	localparam logic [31:0] ADDR_REMAP_CONTROL      = 32'h40010018;

	localparam logic [31:0] RST_PIN_REMAP_ONE      = 32'h00000000;
	localparam logic [31:0] RST_EXT_IRQ_CONFIG     = 32'h00000000;
	localparam logic [31:0] RST_REMAP_CONTROL      = 32'h00000045;

	// Bits 31..27 reserved
	localparam logic [31:0] MASK_PIN_REMAP_ONE     = 32'h07FFFFFF;
	localparam logic [3:0]  FULL_WORD_STROBE       = 4'hF;

	// ------------------------------------------------------------
	// Field positions of the remap word
	// ------------------------------------------------------------
	localparam int DEBUG_SEL_LSB = 24;
	localparam int DEBUG_SEL_W   = 3;
	localparam int PROG_IO_BIT   = 23;
	localparam int TIM3_LSB      = 21;
	localparam int TIM3_W        = 2;
	localparam int TIM2_LSB      = 18;
	localparam int TIM2_W        = 3;
	localparam int TIM1_LSB      = 15;
	localparam int TIM1_W        = 3;

	localparam logic [2:0] DEBUG_SEL_GPIO = 3'h4;

	// ------------------------------------------------------------
	// Pin codes
	// ------------------------------------------------------------
	localparam int PIN_W = 7;
	localparam logic [1:0] PORT_A = 2'h0;
	localparam logic [1:0] PORT_B = 2'h1;
	localparam logic [1:0] PORT_C = 2'h2;
	localparam logic [1:0] PORT_D = 2'h3;
	localparam logic [PIN_W-1:0] PIN_NONE = 7'h7F;
	localparam int TIMER_SIGNALS = 9;

	function automatic logic [PIN_W-1:0] pin_code(
		input logic [1:0] port,
		input logic [4:0] num
	);
		pin_code = {port, num};
	endfunction : pin_code

endpackage : alt_function_io_pkg

// ==== rtl/reg_access_if.sv ====
// Purpose: Carries decoded register accesses from the bus slave.
// Assumes: One clock domain.
// Notes:   wr is a one-cycle strobe at the completing edge.
`timescale 1ns/100ps
interface reg_access_if;
	logic [31:0] addr;
	logic [31:0] wdata;
	logic        wr;
	logic [31:0] rdata;
	logic        hit;

	modport slave (
		output addr,
		output wdata,
		output wr,
		input  rdata,
		input  hit
	);

	modport regs (
		input  addr,
		input  wdata,
		input  wr,
		output rdata,
		output hit
	);
endinterface : reg_access_if

// ==== rtl/apb_word_slave.sv ====
// Purpose: APB4 slave front end with one wait state.
// Assumes: Master holds the request until pready is seen high.
// Notes:   Narrow writes and unmapped addresses end with pslverr.
`timescale 1ns/100ps
module apb_word_slave (
	input  wire logic        i_clk,
	input  wire logic        i_rstn,
	input  wire logic        i_psel,
	input  wire logic        i_penable,
	input  wire logic        i_pwrite,
	input  wire logic [31:0] i_paddr,
	input  wire logic [31:0] i_pwdata,
	input  wire logic [3:0]  i_pstrb,
	output logic      [31:0] o_prdata,
	output logic             o_pready,
	output logic             o_pslverr,
	reg_access_if.slave      bus
);
	logic access;
	logic bad;

	assign access = i_psel & i_penable;
	// Only whole-word writes are accepted
	assign bad = ~bus.hit |
		(i_pwrite & (i_strb_ok() == 1'b0));

	function automatic logic i_strb_ok();
		i_strb_ok = (i_pstrb == alt_function_io_pkg::FULL_WORD_STROBE);
	endfunction : i_strb_ok

	assign bus.addr  = i_paddr;
	assign bus.wdata = i_pwdata;
	// Write lands on the edge where the master sees pready
	assign bus.wr    = access & o_pready & i_pwrite & ~bad;

	always_ff @(posedge i_clk) begin
		if (!i_rstn) begin
			o_pready <= 1'b0;
		end else begin
			o_pready <= access & ~o_pready;
		end
	end

	always_ff @(posedge i_clk) begin
		if (!i_rstn) begin
			o_prdata  <= 32'h00000000;
			o_pslverr <= 1'b0;
		end else if (access & ~o_pready) begin
			o_prdata  <= (i_pwrite | bad) ? 32'h00000000 : bus.rdata;
			o_pslverr <= bad;
		end else begin
			o_prdata  <= 32'h00000000;
			o_pslverr <= 1'b0;
		end
	end
endmodule : apb_word_slave

// ==== rtl/alt_function_remap_mux.sv ====
// Purpose: Remap register bank and pin routing for timers and debug port.
// Assumes: APB master on I_REF_CLK; synchronous active-low reset.
// Notes:   Each pin output is a 7-bit code, {port, number}, 7F = unused.
//
// Added by the designer: the APB register port.
`timescale 1ns/100ps
module alt_function_remap_mux (
	input  wire logic        I_REF_CLK,
	input  wire logic        I_RSTN,
	input  wire logic        I_PSEL,
	input  wire logic        I_PENABLE,
	input  wire logic        I_PWRITE,
	input  wire logic [31:0] I_PADDR,
	input  wire logic [31:0] I_PWDATA,
	input  wire logic [3:0]  I_PSTRB,
	output logic      [31:0] O_PRDATA,
	output logic             O_PREADY,
	output logic             O_PSLVERR,
	output logic             O_DEBUG_PORT_EN,
	output logic      [13:0] O_PROG_IO_PINS,
	output logic      [20:0] O_TIM3_PINS,
	output logic      [62:0] O_TIM2_PINS,
	output logic      [62:0] O_TIM1_PINS,
	output logic      [31:0] O_REMAP_WORD,
	output logic      [31:0] O_EXT_IRQ_CONFIG_ONE,
	output logic      [31:0] O_EXT_IRQ_CONFIG_TWO,
	output logic      [31:0] O_REMAP_CONTROL
);
	localparam logic [1:0] PA = alt_function_io_pkg::PORT_A;
	localparam logic [1:0] PB = alt_function_io_pkg::PORT_B;
	localparam logic [1:0] PC = alt_function_io_pkg::PORT_C;
	localparam logic [1:0] PD = alt_function_io_pkg::PORT_D;
	localparam logic [6:0] NO = alt_function_io_pkg::PIN_NONE;

	reg_access_if bus ();

	logic [31:0] pin_remap_one;
	logic [31:0] ext_irq_config_one;
	logic [31:0] ext_irq_config_two;
	logic [31:0] remap_control;
	logic [31:0] next_pin_remap_one;

	logic [2:0]  dbg_sel;
	logic        prog_sel;
	logic [1:0]  tim3_sel;
	logic [2:0]  tim2_sel;
	logic [2:0]  tim1_sel;

	logic        next_debug_en;
	logic [13:0] next_prog_io;
	logic [20:0] next_tim3;
	logic [62:0] next_tim2;
	logic [62:0] next_tim1;

	// ------------------------------------------------------------
	// Bus front end
	// ------------------------------------------------------------
	apb_word_slave u_apb (
		.i_clk     (I_REF_CLK),
		.i_rstn    (I_RSTN),
		.i_psel    (I_PSEL),
		.i_penable (I_PENABLE),
		.i_pwrite  (I_PWRITE),
		.i_paddr   (I_PADDR),
		.i_pwdata  (I_PWDATA),
		.i_pstrb   (I_PSTRB),
		.o_prdata  (O_PRDATA),
		.o_pready  (O_PREADY),
		.o_pslverr (O_PSLVERR),
		.bus       (bus)
	);

	// ------------------------------------------------------------
	// Register decode
	// ------------------------------------------------------------
	always_comb begin
		bus.hit   = 1'b1;
		bus.rdata = 32'h00000000;
		case (bus.addr)
			alt_function_io_pkg::ADDR_PIN_REMAP_ONE: begin
				bus.rdata = pin_remap_one;
			end
			alt_function_io_pkg::ADDR_EXT_IRQ_CONFIG_ONE: begin
				bus.rdata = ext_irq_config_one;
			end
			alt_function_io_pkg::ADDR_EXT_IRQ_CONFIG_TWO: begin
				bus.rdata = ext_irq_config_two;
			end
			alt_function_io_pkg::ADDR_REMAP_CONTROL: begin
				bus.rdata = remap_control;
			end
			default: begin
				bus.hit = 1'b0;
			end
		endcase
	end

	// Remap word is computed ahead so the routing flops load in step
	always_comb begin
		if (!I_RSTN) begin
			next_pin_remap_one = alt_function_io_pkg::RST_PIN_REMAP_ONE;
		end else if (bus.wr && bus.addr ==
				alt_function_io_pkg::ADDR_PIN_REMAP_ONE) begin
			next_pin_remap_one = bus.wdata &
				alt_function_io_pkg::MASK_PIN_REMAP_ONE;
		end else begin
			next_pin_remap_one = pin_remap_one;
		end
	end

	always_ff @(posedge I_REF_CLK) begin
		pin_remap_one <= next_pin_remap_one;
	end

	always_ff @(posedge I_REF_CLK) begin
		if (!I_RSTN) begin
			ext_irq_config_one <= alt_function_io_pkg::RST_EXT_IRQ_CONFIG;
			ext_irq_config_two <= alt_function_io_pkg::RST_EXT_IRQ_CONFIG;
		end else if (bus.wr) begin
			if (bus.addr == alt_function_io_pkg::ADDR_EXT_IRQ_CONFIG_ONE) begin
				ext_irq_config_one <= bus.wdata;
			end
			if (bus.addr == alt_function_io_pkg::ADDR_EXT_IRQ_CONFIG_TWO) begin
				ext_irq_config_two <= bus.wdata;
			end
		end
	end

	always_ff @(posedge I_REF_CLK) begin
		if (!I_RSTN) begin
			remap_control <= alt_function_io_pkg::RST_REMAP_CONTROL;
		end else if (bus.wr &&
				bus.addr == alt_function_io_pkg::ADDR_REMAP_CONTROL) begin
			remap_control <= bus.wdata;
		end
	end

	// ------------------------------------------------------------
	// Field extraction
	// ------------------------------------------------------------
	assign dbg_sel  = next_pin_remap_one[alt_function_io_pkg::DEBUG_SEL_LSB +:
		alt_function_io_pkg::DEBUG_SEL_W];
	assign prog_sel = next_pin_remap_one[alt_function_io_pkg::PROG_IO_BIT];
	assign tim3_sel = next_pin_remap_one[alt_function_io_pkg::TIM3_LSB +:
		alt_function_io_pkg::TIM3_W];
	assign tim2_sel = next_pin_remap_one[alt_function_io_pkg::TIM2_LSB +:
		alt_function_io_pkg::TIM2_W];
	// Spans bits 17..15 across the half-word edge
	assign tim1_sel = next_pin_remap_one[alt_function_io_pkg::TIM1_LSB +:
		alt_function_io_pkg::TIM1_W];

	function automatic logic [6:0] p(
		input logic [1:0] port,
		input logic [4:0] num
	);
		p = alt_function_io_pkg::pin_code(port, num);
	endfunction : p

	// Order: ch1 ch2 ch3 ch4 trigger break comp1 comp2 comp3, ch1 at LSB
	function automatic logic [62:0] set9(
		input logic [6:0] ch1,
		input logic [6:0] ch2,
		input logic [6:0] ch3,
		input logic [6:0] ch4,
		input logic [6:0] trg,
		input logic [6:0] brk,
		input logic [6:0] cn1,
		input logic [6:0] cn2,
		input logic [6:0] cn3
	);
		set9 = {cn3, cn2, cn1, brk, trg, ch4, ch3, ch2, ch1};
	endfunction : set9

	// ------------------------------------------------------------
	// Debug port and programmable controller
	// ------------------------------------------------------------
	always_comb begin
		// Invalid codes keep the debug port alive, the safer failure
		next_debug_en = (dbg_sel != alt_function_io_pkg::DEBUG_SEL_GPIO);
		if (prog_sel) begin
			next_prog_io = {p(PC, 5'h13), p(PC, 5'h07)};
		end else begin
			next_prog_io = {p(PC, 5'h13), p(PC, 5'h12)};
		end
	end

	// ------------------------------------------------------------
	// Timer 3
	// ------------------------------------------------------------
	always_comb begin
		// Trigger never moves
		next_tim3 = {p(PD, 5'h02), p(PA, 5'h07), p(PA, 5'h06)};
		case (tim3_sel)
			2'h0: begin
				next_tim3[13:0] = {p(PA, 5'h07), p(PA, 5'h06)};
			end
			2'h1: begin
				next_tim3[13:0] = {p(PB, 5'h05), p(PB, 5'h04)};
			end
			2'h2: begin
				next_tim3[13:0] = {p(PC, 5'h12), p(PC, 5'h13)};
			end
			default: begin
				next_tim3[13:0] = {p(PA, 5'h04), p(PA, 5'h03)};
			end
		endcase
	end

	// ------------------------------------------------------------
	// Timer 2
	// ------------------------------------------------------------
	always_comb begin
		case (tim2_sel)
			3'h0: begin
				next_tim2 = set9(p(PA, 5'h00), p(PA, 5'h01), p(PA, 5'h02),
					p(PA, 5'h03), p(PA, 5'h13), p(PA, 5'h14),
					p(PA, 5'h15), p(PA, 5'h16), p(PA, 5'h17));
			end
			3'h1: begin
				next_tim2 = set9(p(PB, 5'h15), p(PB, 5'h0F), p(PA, 5'h02),
					p(PA, 5'h03), p(PA, 5'h12), p(PA, 5'h09),
					p(PA, 5'h0C), p(PA, 5'h0D), p(PA, 5'h0E));
			end
			3'h2: begin
				next_tim2 = set9(p(PA, 5'h00), p(PA, 5'h01), p(PB, 5'h03),
					p(PB, 5'h04), p(PA, 5'h13), p(PA, 5'h14),
					p(PC, 5'h03), p(PA, 5'h16), p(PA, 5'h17));
			end
			3'h3: begin
				next_tim2 = set9(p(PB, 5'h15), p(PB, 5'h0F), p(PB, 5'h03),
					p(PB, 5'h04), p(PA, 5'h12), p(PA, 5'h09),
					p(PA, 5'h0C), p(PA, 5'h0D), p(PA, 5'h0E));
			end
			3'h4: begin
				next_tim2 = set9(p(PB, 5'h10), p(PB, 5'h11), p(PB, 5'h12),
					p(PB, 5'h13), p(PC, 5'h04), p(PC, 5'h00),
					p(PC, 5'h01), p(PC, 5'h02), p(PC, 5'h03));
			end
			3'h5: begin
				next_tim2 = set9(p(PC, 5'h13), p(PA, 5'h0C), p(PA, 5'h0D),
					p(PC, 5'h00), p(PA, 5'h02), p(PB, 5'h04),
					p(PC, 5'h12), p(PB, 5'h0C), p(PB, 5'h03));
			end
			// 110 and 111 share one set
			default: begin
				next_tim2 = set9(p(PC, 5'h13), p(PC, 5'h0E),
					p(PC, 5'h0F), p(PC, 5'h00), p(PA, 5'h02),
					p(PB, 5'h04), p(PB, 5'h0B), p(PB, 5'h0C),
					p(PB, 5'h03));
			end
		endcase
	end

	// ------------------------------------------------------------
	// Timer 1
	// ------------------------------------------------------------
	always_comb begin
		case (tim1_sel)
			3'h0: begin
				next_tim1 = set9(p(PB, 5'h09), p(PB, 5'h0A), p(PB, 5'h0B),
					p(PC, 5'h10), p(PC, 5'h11), p(PB, 5'h05),
					p(PB, 5'h06), p(PB, 5'h07), p(PB, 5'h08));
			end
			3'h1: begin
				next_tim1 = set9(p(PB, 5'h09), p(PB, 5'h0A), p(PB, 5'h0B),
					p(PC, 5'h10), p(PC, 5'h11), p(PA, 5'h06),
					p(PA, 5'h07), p(PB, 5'h00), p(PB, 5'h01));
			end
			3'h2: begin
				next_tim1 = set9(p(PB, 5'h09), p(PB, 5'h0A), p(PB, 5'h0B),
					p(PB, 5'h0C), p(PC, 5'h12), p(PB, 5'h05),
					p(PB, 5'h06), p(PB, 5'h07), p(PB, 5'h08));
			end
			3'h3: begin
				next_tim1 = set9(p(PC, 5'h00), p(PC, 5'h01), p(PC, 5'h02),
					p(PC, 5'h03), p(PC, 5'h12), p(PC, 5'h04),
					p(PC, 5'h05), p(PC, 5'h06), p(PC, 5'h07));
			end
			// Only channel 3 and the trigger are usable in this set
			default: begin
				next_tim1 = set9(NO, NO, p(PC, 5'h0E), NO,
					p(PC, 5'h0F), NO, NO, NO, NO);
			end
		endcase
	end

	// ------------------------------------------------------------
	// Routing outputs
	// ------------------------------------------------------------
	// Loaded from the next remap word, so routing changes right after
	// the completing write edge
	always_ff @(posedge I_REF_CLK) begin
		O_DEBUG_PORT_EN <= next_debug_en;
		O_PROG_IO_PINS  <= next_prog_io;
		O_TIM3_PINS     <= next_tim3;
		O_TIM2_PINS     <= next_tim2;
		O_TIM1_PINS     <= next_tim1;
		O_REMAP_WORD    <= next_pin_remap_one;
	end

	// Pins still need alternate-function push-pull set in the port
	// configuration before these routes drive anything
	always_ff @(posedge I_REF_CLK) begin
		if (!I_RSTN) begin
			O_EXT_IRQ_CONFIG_ONE <= alt_function_io_pkg::RST_EXT_IRQ_CONFIG;
			O_EXT_IRQ_CONFIG_TWO <= alt_function_io_pkg::RST_EXT_IRQ_CONFIG;
			O_REMAP_CONTROL      <= alt_function_io_pkg::RST_REMAP_CONTROL;
		end else begin
			O_EXT_IRQ_CONFIG_ONE <= ext_irq_config_one;
			O_EXT_IRQ_CONFIG_TWO <= ext_irq_config_two;
			O_REMAP_CONTROL      <= remap_control;
		end
	end
endmodule : alt_function_remap_mux

// ==== verification/gpio_pin_partner.sv ====
// Purpose: GPIO pin side that receives one remapped timer output.
// Assumes: Pin codes are {port, number}.
// Notes:   The pin is driven only when its config selects the peripheral.
`timescale 1ns/100ps
module gpio_pin_partner (
	input  wire logic [6:0] i_pin,
	input  wire logic [6:0] i_port_pin,
	input  wire logic [1:0] i_pin_config_field,
	output logic            o_driven
);
	// Any other config keeps the port's own data on the pin
	assign o_driven = (i_pin == i_port_pin) && (i_pin_config_field == 2'h2);
endmodule : gpio_pin_partner

// ==== verification/alt_function_remap_properties.sv ====
// Purpose: Handshake and routing properties of the remap block.
// Assumes: One clock domain, synchronous active-low reset.
// Notes:   Routing is judged against the data of the completing write.
`timescale 1ns/100ps
module alt_function_remap_properties (
	input wire logic        I_REF_CLK,
	input wire logic        I_RSTN,
	input wire logic        I_PSEL,
	input wire logic        I_PENABLE,
	input wire logic        I_PWRITE,
	input wire logic [31:0] I_PADDR,
	input wire logic [31:0] I_PWDATA,
	input wire logic [3:0]  I_PSTRB,
	input wire logic        O_PREADY,
	input wire logic        O_PSLVERR,
	input wire logic        O_DEBUG_PORT_EN,
	input wire logic [13:0] O_PROG_IO_PINS,
	input wire logic [20:0] O_TIM3_PINS,
	input wire logic [62:0] O_TIM2_PINS,
	input wire logic [62:0] O_TIM1_PINS,
	input wire logic [31:0] O_REMAP_WORD
);
	logic [31:0] wd;
	logic [13:0] t3;
	always_ff @(posedge I_REF_CLK) begin
		wd <= I_PWDATA;
	end
	always_comb begin
		case (wd[22:21])
			2'h0: t3 = {7'h07, 7'h06};
			2'h1: t3 = {7'h25, 7'h24};
			2'h2: t3 = {7'h52, 7'h53};
			default: t3 = {7'h04, 7'h03};
		endcase
	end
	default clocking cb @(posedge I_REF_CLK); endclocking
	default disable iff (!I_RSTN);
	sequence s_done;
		I_PSEL && I_PENABLE && O_PREADY && I_PWRITE;
	endsequence
	sequence s_remap_wr;
		s_done ##0 (I_PSTRB == 4'hF &&
			I_PADDR == alt_function_io_pkg::ADDR_PIN_REMAP_ONE);
	endsequence
	a_ready_wait: assert property (
		I_PSEL && I_PENABLE && !O_PREADY |=> O_PREADY)
		else $error("no ready after one wait state");
	a_ready_pulse: assert property (O_PREADY |=> !O_PREADY)
		else $error("ready longer than one cycle");
	a_narrow_refused: assert property (
		s_done ##0 I_PSTRB != 4'hF |-> O_PSLVERR)
		else $error("narrow write not refused");
	a_reserved_zero: assert property (O_REMAP_WORD[31:27] == 5'h00)
		else $error("reserved remap bits set");
	a_trigger_fixed: assert property (O_TIM3_PINS[20:14] == 7'h62)
		else $error("timer three trigger moved");
	a_debug_route: assert property (
		s_remap_wr |=> O_DEBUG_PORT_EN == (wd[26:24] != 3'h4))
		else $error("debug enable wrong");
	a_prog_route: assert property (
		s_remap_wr |=> O_PROG_IO_PINS == {7'h53, wd[23] ? 7'h47 : 7'h52})
		else $error("controller lines wrong");
	a_tim3_route: assert property (
		s_remap_wr |=> O_TIM3_PINS[13:0] == t3)
		else $error("timer three channels wrong");
	a_tim2_upper: assert property (
		s_remap_wr ##0 I_PWDATA[20:19] == 2'h3 |=> O_TIM2_PINS ==
		{7'h23, 7'h2C, 7'h2B, 7'h24, 7'h02, 7'h40, 7'h4F, 7'h4E, 7'h53})
		else $error("timer two upper set wrong");
	a_route_hold: assert property (
		!(I_PSEL && I_PENABLE && O_PREADY) |=> $stable(O_TIM1_PINS))
		else $error("timer one routing moved without write");
endmodule : alt_function_remap_properties

// ==== verification/testbench.sv ====
// Purpose: Self-checking bench of the remap block over APB.
// Assumes: One wait state per transfer.
// Notes:   Routing is sampled just after the completing edge.
`timescale 1ns/100ps
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin n_fail++; \
	$display("[FAIL] %0t %h %h", $time, (a), (b)); end end
module testbench;
	logic        clk = 1'b0, rstn = 1'b0, psel = 1'b0, penable = 1'b0;
	logic        pwrite = 1'b0, pready, pslverr, dbg, drv, err;
	logic [31:0] paddr = '0, pwdata = '0, prdata, rw, rd;
	logic [3:0]  pstrb = 4'h0;
	logic [1:0]  cfg = 2'h2;
	logic [13:0] prog;
	logic [20:0] t3;
	logic [62:0] t2, t1;
	logic [31:0] e1, e2, ctl;
	int          n_fail = 0, compares = 0;
	localparam logic [31:0] RM = alt_function_io_pkg::ADDR_PIN_REMAP_ONE;
	always #12.5 clk = ~clk;
	alt_function_remap_mux i_alt_function_remap_mux (.I_REF_CLK(clk),
		.I_RSTN(rstn), .I_PSEL(psel), .I_PENABLE(penable),
		.I_PWRITE(pwrite), .I_PADDR(paddr), .I_PWDATA(pwdata),
		.I_PSTRB(pstrb), .O_PRDATA(prdata), .O_PREADY(pready),
		.O_PSLVERR(pslverr), .O_DEBUG_PORT_EN(dbg),
		.O_PROG_IO_PINS(prog), .O_TIM3_PINS(t3), .O_TIM2_PINS(t2),
		.O_TIM1_PINS(t1), .O_REMAP_WORD(rw), .O_EXT_IRQ_CONFIG_ONE(e1),
		.O_EXT_IRQ_CONFIG_TWO(e2), .O_REMAP_CONTROL(ctl));
	gpio_pin_partner i_gpio_pin_partner (.i_pin(t3[6:0]),
		.i_port_pin(7'h24), .i_pin_config_field(cfg), .o_driven(drv));
	task end_sim;
		if (n_fail == 0 && compares > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : end_sim
	task apb(input logic [31:0] a, input logic w, input logic [31:0] d,
		input logic [3:0] s);
		int n;
		@(posedge clk);
		{psel, penable, pwrite, paddr, pwdata, pstrb} <= {2'b10, w, a, d, s};
		@(posedge clk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (pready !== 1'b1) begin
			n_fail++;
			end_sim();
		end
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task wr(input logic [31:0] a, input logic [31:0] d);
		apb(a, 1'b1, d, 4'hF);
		#1;
	endtask : wr
	task rdc(input logic [31:0] a, input logic [31:0] x, input logic e);
		apb(a, 1'b0, 32'h00000000, 4'hF);
		`CHK(rd, x)
		`CHK(err, e)
	endtask : rdc
	task t_reset;
		rdc(RM, 32'h00000000, 1'b0);
		rdc(32'h40010008, 32'h00000000, 1'b0);
		rdc(32'h4001000C, 32'h00000000, 1'b0);
		rdc(32'h40010018, 32'h00000045, 1'b0);
		`CHK(dbg, 1'b1)
		`CHK(rw, 32'h00000000)
		`CHK(prog, {7'h53, 7'h52})
		`CHK(t3, {7'h62, 7'h07, 7'h06})
		`CHK(e1, 32'h00000000)
		`CHK(e2, 32'h00000000)
		`CHK(ctl, 32'h00000045)
		`CHK(t2, {7'h17,7'h16,7'h15,7'h14,7'h13,7'h03,7'h02,7'h01,7'h00})
		`CHK(t1, {7'h28,7'h27,7'h26,7'h25,7'h51,7'h50,7'h2B,7'h2A,7'h29})
	endtask : t_reset
	task t_regs;
		wr(32'h40010008, 32'hA5A5C3C3);
		wr(32'h4001000C, 32'h5A5A3C3C);
		rdc(32'h40010008, 32'hA5A5C3C3, 1'b0);
		rdc(32'h4001000C, 32'h5A5A3C3C, 1'b0);
		`CHK(e1, 32'hA5A5C3C3)
		`CHK(e2, 32'h5A5A3C3C)
		rdc(32'h40010010, 32'h00000000, 1'b1);
		wr(RM, 32'hFBFFFFFF);
		rdc(RM, 32'h03FFFFFF, 1'b0);
		`CHK(rw, 32'h03FFFFFF)
	endtask : t_regs
	task t_debug;
		for (int i = 0; i < 5; i++) begin
			wr(RM, 32'(i) << 24);
			`CHK(dbg, 1'(i != 4))
			`CHK(rw, 32'(i) << 24)
		end
	endtask : t_debug
	task t_routes;
		static logic [13:0] x [4] = '{{7'h07,7'h06}, {7'h25,7'h24},
			{7'h52,7'h53},
			{7'h04,7'h03}};
		for (int i = 0; i < 4; i++) begin
			wr(RM, (32'(i) << 21) | (32'(i & 1) << 23));
			`CHK(t3, {7'h62, x[i]})
			`CHK(prog, {7'h53, (i & 1) ? 7'h47 : 7'h52})
			`CHK(drv, 1'(i == 1))
			if (i == 1) begin
				cfg <= 2'h0;
				#1;
				`CHK(drv, 1'b0)
				cfg <= 2'h2;
			end
		end
	endtask : t_routes
	task t_timers;
		wr(RM, 32'h00180000);
		`CHK(t2, {7'h23,7'h2C,7'h2B,7'h24,7'h02,7'h40,7'h4F,7'h4E,7'h53})
		wr(RM, 32'h001C0000);
		`CHK(t2, {7'h23,7'h2C,7'h2B,7'h24,7'h02,7'h40,7'h4F,7'h4E,7'h53})
		wr(RM, 32'h00008000);
		`CHK(t1, {7'h21,7'h20,7'h07,7'h06,7'h51,7'h50,7'h2B,7'h2A,7'h29})
		wr(RM, 32'h00018000);
		`CHK(t1, {7'h47,7'h46,7'h45,7'h44,7'h52,7'h43,7'h42,7'h41,7'h40})
		apb(RM, 1'b1, 32'h04000000, 4'h3);
		`CHK(err, 1'b1)
		rdc(RM, 32'h00018000, 1'b0);
		`CHK(dbg, 1'b1)
	endtask : t_timers
	task t_sets;
		static logic [62:0] x [5] = '{
			{7'h0E,7'h0D,7'h0C,7'h09,7'h12,7'h03,7'h02,7'h2F,7'h35},
			{7'h17,7'h16,7'h43,7'h14,7'h13,7'h24,7'h23,7'h01,7'h00},
			{7'h0E,7'h0D,7'h0C,7'h09,7'h12,7'h24,7'h23,7'h2F,7'h35},
			{7'h43,7'h42,7'h41,7'h40,7'h44,7'h33,7'h32,7'h31,7'h30},
			{7'h23,7'h2C,7'h52,7'h24,7'h02,7'h40,7'h0D,7'h0C,7'h53}};
		for (int i = 1; i < 6; i++) begin
			wr(RM, 32'(i) << 18);
			`CHK(t2, x[i-1])
		end
		wr(RM, 32'h00010000);
		`CHK(t1, {7'h28,7'h27,7'h26,7'h25,7'h52,7'h2C,7'h2B,7'h2A,7'h29})
		wr(RM, 32'h00038000);
		`CHK(t1, {7'h7F,7'h7F,7'h7F,7'h7F,7'h4F,7'h7F,7'h4E,7'h7F,7'h7F})
	endtask : t_sets
	task t_rst;
		wr(RM, 32'h04000000);
		`CHK(dbg, 1'b0)
		@(posedge clk);
		rstn <= 1'b0;
		repeat (2) @(posedge clk);
		rstn <= 1'b1;
		rdc(RM, 32'h00000000, 1'b0);
		rdc(32'h40010008, 32'h00000000, 1'b0);
		`CHK(dbg, 1'b1)
		`CHK(rw, 32'h00000000)
		`CHK(e1, 32'h00000000)
	endtask : t_rst
	initial begin
		repeat (16) @(posedge clk);
		rstn <= 1'b1;
		t_reset();
		t_regs();
		t_debug();
		t_routes();
		t_timers();
		t_sets();
		t_rst();
		end_sim();
	end
endmodule : testbench
bind alt_function_remap_mux alt_function_remap_properties i_props (
	.I_REF_CLK, .I_RSTN, .I_PSEL, .I_PENABLE, .I_PWRITE, .I_PADDR,
	.I_PWDATA, .I_PSTRB, .O_PREADY, .O_PSLVERR, .O_DEBUG_PORT_EN,
	.O_PROG_IO_PINS, .O_TIM3_PINS, .O_TIM2_PINS, .O_TIM1_PINS,
	.O_REMAP_WORD);
